/* io_port_reset_lowpower_cfg_tb_top.sv */
/*
  Testbench for iopr_port: Wishbone tasks and directed tests.
  Assumes iopr_pkg, iopr_port and iopr_ext_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module io_port_reset_lowpower_cfg_tb_top;
  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  logic                cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]          adr = 8'h00;
  logic [31:0]         dat = 32'h0, dat_o, q;
  logic                ack, lp, wake, irq, match = 1'b0;
  logic [7:0]          pin, ext_en = 8'h00, ext_v = 8'h00;
  iopr_pkg::iopr_pad_t pad, pad_keep;
  iopr_pkg::iopr_sio_t special_io_pin;
  int                  n_mismatch = 0, checks_done = 0, cycles = 0;
  always #2.5 clk = ~clk;
  iopr_port i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_i(pin), .pad_o(pad),
    .sio_o(special_io_pin), .bus_addr_match(match), .lp_mode_o(lp), .wake_o(wake),
    .irq(irq));
  iopr_ext_model i_ext (.pad(pad), .ext_en(ext_en), .ext_v(ext_v),
    .pin(pin));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) n_mismatch++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    chk({pad.ana, pad.oe, pad.pu, pad.pd}, 32'hFF000000);
    chk({31'h0, irq}, 32'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Drive pin 0 to v and wait four clocks
  task automatic edge_to(input logic v);
    ext_v[0] <= v;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    do_reset();
    wr(iopr_pkg::ADR_NVCFG, {30'h0, iopr_pkg::RCFG_PU});
    do_reset();
    rd(iopr_pkg::ADR_RSTCFG, {30'h0, iopr_pkg::RCFG_PU});
    chk({24'h0, pad.pu}, 32'hFF);
    wr(iopr_pkg::ADR_RSTCFG, {30'h0, iopr_pkg::RCFG_PD});
    repeat (2) @(posedge clk);
    chk({pad.pu, pad.pd}, 32'h00FF);
    $display("test reset configuration done");
    ext_en <= 8'h01;
    wr(iopr_pkg::ADR_DM_LO, {29'h0, iopr_pkg::DM_HIZ_DIG});
    wr(iopr_pkg::ADR_IMASK, 32'h1);
    for (int e = 0; e < 4; e++) begin
      wr(iopr_pkg::ADR_IEDGE, e);
      wr(iopr_pkg::ADR_ISTAT, 32'hFF);
      edge_to(1'b1);
      rd(iopr_pkg::ADR_ISTAT, (e == 1 || e == 3) ? 32'h1 : 32'h0);
      chk({31'h0, irq}, {31'h0, (e == 1 || e == 3)});
      wr(iopr_pkg::ADR_ISTAT, 32'hFF);
      edge_to(1'b0);
      rd(iopr_pkg::ADR_ISTAT, (e == 2 || e == 3) ? 32'h1 : 32'h0);
      chk({31'h0, irq}, {31'h0, (e == 2 || e == 3)});
    end
    wr(iopr_pkg::ADR_ISTAT, 32'hFF);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(iopr_pkg::ADR_IMASK, 32'h0);
    edge_to(1'b1);
    rd(iopr_pkg::ADR_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test pin interrupts done");
    wr(iopr_pkg::ADR_ISTAT, 32'hFF);
    wr(iopr_pkg::ADR_IMASK, 32'h1);
    wr(iopr_pkg::ADR_IEDGE, {30'h0, iopr_pkg::EDGE_FALL});
    wr(iopr_pkg::ADR_CTRL, 32'h3);
    @(posedge clk);
    pad_keep = pad;
    chk({31'h0, lp}, 32'h1);
    edge_to(1'b0);
    chk({31'h0, pad == pad_keep}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    match <= 1'b1;
    @(posedge clk);
    match <= 1'b0;
    q = 32'h0;
    repeat (4) begin
      @(posedge clk);
      q[0] = q[0] | wake;
    end
    chk(q, 32'h1);
    $display("test low power done");
    wr(iopr_pkg::ADR_SIOCFG, {27'h0, 2'b01, iopr_pkg::THR_AGLOBAL});
    @(posedge clk);
    chk({27'h0, special_io_pin}, {27'h0, iopr_pkg::THR_AGLOBAL, 2'b10});
    rd(iopr_pkg::ADR_SIOCFG, {27'h0, 2'b01, iopr_pkg::THR_AGLOBAL});
    wr(iopr_pkg::ADR_SIOCFG, {27'h0, 2'b10, iopr_pkg::THR_40_IO});
    @(posedge clk);
    chk({27'h0, special_io_pin}, {27'h0, iopr_pkg::THR_40_IO, 2'b01});
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    $display("test special pair and unmapped done");
    final_report();
  end
endmodule // io_port_reset_lowpower_cfg_tb_top
`default_nettype wire

/* iopr_edge.sv */
/*
  One pin edge detector for the port interrupt unit.
  Assumes the pin input is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module iopr_edge (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Pin and mode
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  // Event
  output logic            evt
);
  logic prev_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

  always_comb begin
    case (mode)
      iopr_pkg::EDGE_RISE: evt = pin & ~prev_r;
      iopr_pkg::EDGE_FALL: evt = ~pin & prev_r;
      iopr_pkg::EDGE_BOTH: evt = pin ^ prev_r;
      default:             evt = 1'b0;
    endcase
  end
endmodule // iopr_edge
`default_nettype wire

/* iopr_ext_model.sv */
/*
  Far-side model: external circuit and bus pull-up on the eight pins.
  Assumes pad_o of the port and a bench-controlled external driver.
*/
`timescale 1ns/1ps
`default_nettype none
module iopr_ext_model (
  // Pad controls from the port
  input  wire iopr_pkg::iopr_pad_t pad,
  // External driver per pin
  input  wire logic [7:0]          ext_en,
  input  wire logic [7:0]          ext_v,
  // Resolved pin levels
  output logic      [7:0]          pin
);
  // Bus pull-up wins when nobody drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = pad.oe[i] ? pad.o[i] : (ext_en[i] ? ext_v[i] : 1'b1);
    end
  end
endmodule // iopr_ext_model
`default_nettype wire

/* iopr_pkg.sv */
/*
  Constants, register map and carrier types for the I/O port reset,
  low-power and configuration block.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`default_nettype none
package iopr_pkg;
  localparam int NPIN = 8;
  localparam logic [7:0] ADR_DM_LO  = 8'h00;
  localparam logic [7:0] ADR_DM_HI  = 8'h04;
  localparam logic [7:0] ADR_OUT    = 8'h08;
  localparam logic [7:0] ADR_IN     = 8'h0C;
  localparam logic [7:0] ADR_IEDGE  = 8'h10;
  localparam logic [7:0] ADR_ISTAT  = 8'h14;
  localparam logic [7:0] ADR_IMASK  = 8'h18;
  localparam logic [7:0] ADR_RSTCFG = 8'h1C;
  localparam logic [7:0] ADR_NVCFG  = 8'h20;
  localparam logic [7:0] ADR_SIOCFG = 8'h24;
  localparam logic [7:0] ADR_CTRL   = 8'h28;
  // Reset configuration field codes
  localparam logic [1:0] RCFG_HIZ = 2'h0;
  localparam logic [1:0] RCFG_PD  = 2'h1;
  localparam logic [1:0] RCFG_PU  = 2'h2;
  localparam logic [1:0] NV_RESET = 2'h0;
  // Drive mode codes
  localparam logic [2:0] DM_HIZ_ANA = 3'h0;
  localparam logic [2:0] DM_HIZ_DIG = 3'h1;
  localparam logic [2:0] DM_PU      = 3'h2;
  localparam logic [2:0] DM_PD      = 3'h3;
  localparam logic [2:0] DM_OD_LO   = 3'h4;
  localparam logic [2:0] DM_OD_HI   = 3'h5;
  localparam logic [2:0] DM_STRONG  = 3'h6;
  localparam logic [2:0] DM_PUPD    = 3'h7;
  // Interrupt edge codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Special I/O config and control register bit positions
  localparam int SIO_THR_LSB = 0;
  localparam int SIO_HYS0    = 3;
  localparam int SIO_HYS1    = 4;
  localparam int CTRL_LP     = 0;
  localparam int CTRL_WAKEEN = 1;
  // Threshold selections
  localparam logic [2:0] THR_HALF_IO = 3'h0;
  localparam logic [2:0] THR_40_IO   = 3'h1;
  localparam logic [2:0] THR_HALF_RF = 3'h2;
  localparam logic [2:0] THR_REF     = 3'h3;
  localparam logic [2:0] THR_AGLOBAL = 3'h4;

  typedef struct packed {
    logic [2:0] thr_sel;
    logic       hys0;
    logic       hys1;
  } iopr_sio_t;

  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] pd;
    logic [NPIN-1:0] ana;
  } iopr_pad_t;
endpackage : iopr_pkg
`default_nettype wire

/* iopr_port.sv */
/*
  Port of eight pins: drive modes, reset configuration with nonvolatile
  backing, interrupt unit, special I/O comparator pair, low-power hold.
  Assumes a classic Wishbone master; pin inputs synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module iopr_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic [7:0]  pin_i,
  output iopr_pkg::iopr_pad_t pad_o,
  // Special I/O pair comparator control
  output iopr_pkg::iopr_sio_t sio_o,
  // Low power and wake
  input  wire logic        bus_addr_match,
  output logic             lp_mode_o,
  output logic             wake_o,
  // Interrupt
  output logic             irq
);
  localparam int N = iopr_pkg::NPIN;

  logic [3*N-1:0] dm_r;
  logic [N-1:0]   out_r;
  logic [2*N-1:0] edge_r;
  logic [N-1:0]   stat_r;
  logic [N-1:0]   mask_r;
  logic [1:0]     rcfg_r;
  // Power-on content of the store until software first programs it
  logic [1:0]     nv_r = iopr_pkg::NV_RESET;
  logic [4:0]     sio_r;
  logic [1:0]     ctrl_r;
  logic           load_r;
  logic [N-1:0]   evt;
  logic           wr;
  logic           rd;
  logic [31:0]    rdat;

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // Nonvolatile store: only a write changes it, never cleared by reset
  always_ff @(posedge clk) begin
    if (wr && wb_adr_i == iopr_pkg::ADR_NVCFG && wb_sel_i[0]) begin
      nv_r <= wb_dat_i[1:0];
    end
  end

  // One load pulse right after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_r <= 1'b1;
    end else begin
      load_r <= 1'b0;
    end
  end

  // Working reset configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rcfg_r <= iopr_pkg::RCFG_HIZ;
    end else if (load_r) begin
      rcfg_r <= nv_r;
    end else if (wr && wb_adr_i == iopr_pkg::ADR_RSTCFG && wb_sel_i[0]) begin
      rcfg_r <= wb_dat_i[1:0];
    end
  end

  // Drive modes: reset config seeds them, software overrides
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dm_r <= '0;
    end else if (load_r || (wr && wb_adr_i == iopr_pkg::ADR_RSTCFG)) begin
      for (int i = 0; i < N; i++) begin
        case (load_r ? nv_r : wb_dat_i[1:0])
          iopr_pkg::RCFG_PD: dm_r[3*i +: 3] <= iopr_pkg::DM_PD;
          iopr_pkg::RCFG_PU: dm_r[3*i +: 3] <= iopr_pkg::DM_PU;
          default:           dm_r[3*i +: 3] <= iopr_pkg::DM_HIZ_ANA;
        endcase
      end
    end else if (wr && wb_adr_i == iopr_pkg::ADR_DM_LO) begin
      dm_r[11:0] <= wb_dat_i[11:0];
    end else if (wr && wb_adr_i == iopr_pkg::ADR_DM_HI) begin
      dm_r[23:12] <= wb_dat_i[11:0];
    end
  end

  // Output data, edge modes, mask, special I/O and control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_r  <= '0;
      edge_r <= '0;
      mask_r <= '0;
      sio_r  <= '0;
      ctrl_r <= '0;
    end else if (load_r) begin
      // Data selects the pull state of the resistive modes: high for pull-up, low for pull-down
      out_r <= (nv_r == iopr_pkg::RCFG_PU) ? '1 : '0;
    end else if (wr) begin
      case (wb_adr_i)
        iopr_pkg::ADR_OUT:    out_r  <= wb_dat_i[N-1:0];
        iopr_pkg::ADR_RSTCFG:
          out_r <= (wb_dat_i[1:0] == iopr_pkg::RCFG_PU) ? '1 : '0;
        iopr_pkg::ADR_IEDGE:  edge_r <= wb_dat_i[2*N-1:0];
        iopr_pkg::ADR_IMASK:  mask_r <= wb_dat_i[N-1:0];
        iopr_pkg::ADR_SIOCFG: sio_r  <= wb_dat_i[4:0];
        iopr_pkg::ADR_CTRL:   ctrl_r <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // Edge detectors run regardless of low-power mode
  for (genvar g = 0; g < N; g++) begin : g_edge
    iopr_edge u_edge (
      .clk  (clk),
      .rstn (rstn),
      .pin  (pin_i[g]),
      .mode (edge_r[2*g +: 2]),
      .evt  (evt[g])
    );
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~((wr && wb_adr_i == iopr_pkg::ADR_ISTAT)
                 ? wb_dat_i[N-1:0] : '0)) | evt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_r | evt) & mask_r);
    end
  end

  // Wake on pin interrupt or dedicated-pin bus address match
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= ctrl_r[iopr_pkg::CTRL_LP] &
                (|(evt & mask_r) |
                 (bus_addr_match & ctrl_r[iopr_pkg::CTRL_WAKEEN]));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lp_mode_o <= 1'b0;
    end else begin
      lp_mode_o <= ctrl_r[iopr_pkg::CTRL_LP];
    end
  end

  // Pad decode; state comes only from registers so it holds in low power
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_o <= '{o: '0, oe: '0, pu: '0, pd: '0, ana: '1};
    end else begin
      for (int i = 0; i < N; i++) begin
        pad_o.o[i]   <= out_r[i];
        pad_o.ana[i] <= dm_r[3*i +: 3] == iopr_pkg::DM_HIZ_ANA;
        case (dm_r[3*i +: 3])
          iopr_pkg::DM_PU: begin
            pad_o.oe[i] <= ~out_r[i];
            pad_o.pu[i] <= out_r[i];
            pad_o.pd[i] <= 1'b0;
          end
          iopr_pkg::DM_PD: begin
            pad_o.oe[i] <= out_r[i];
            pad_o.pu[i] <= 1'b0;
            pad_o.pd[i] <= ~out_r[i];
          end
          iopr_pkg::DM_OD_LO: begin
            pad_o.oe[i] <= ~out_r[i];
            pad_o.pu[i] <= 1'b0;
            pad_o.pd[i] <= 1'b0;
          end
          iopr_pkg::DM_OD_HI: begin
            pad_o.oe[i] <= out_r[i];
            pad_o.pu[i] <= 1'b0;
            pad_o.pd[i] <= 1'b0;
          end
          iopr_pkg::DM_STRONG: begin
            pad_o.oe[i] <= 1'b1;
            pad_o.pu[i] <= 1'b0;
            pad_o.pd[i] <= 1'b0;
          end
          iopr_pkg::DM_PUPD: begin
            pad_o.oe[i] <= 1'b0;
            pad_o.pu[i] <= out_r[i];
            pad_o.pd[i] <= ~out_r[i];
          end
          default: begin
            pad_o.oe[i] <= 1'b0;
            pad_o.pu[i] <= 1'b0;
            pad_o.pd[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // One threshold and two hysteresis enables for the pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sio_o <= '0;
    end else begin
      sio_o.thr_sel <= sio_r[2:0];
      sio_o.hys0    <= sio_r[iopr_pkg::SIO_HYS0];
      sio_o.hys1    <= sio_r[iopr_pkg::SIO_HYS1];
    end
  end

  always_comb begin
    case (wb_adr_i)
      iopr_pkg::ADR_DM_LO:  rdat = {20'h0, dm_r[11:0]};
      iopr_pkg::ADR_DM_HI:  rdat = {20'h0, dm_r[23:12]};
      iopr_pkg::ADR_OUT:    rdat = {24'h0, out_r};
      iopr_pkg::ADR_IN:     rdat = {24'h0, pin_i};
      iopr_pkg::ADR_IEDGE:  rdat = {16'h0, edge_r};
      iopr_pkg::ADR_ISTAT:  rdat = {24'h0, stat_r};
      iopr_pkg::ADR_IMASK:  rdat = {24'h0, mask_r};
      iopr_pkg::ADR_RSTCFG: rdat = {30'h0, rcfg_r};
      iopr_pkg::ADR_NVCFG:  rdat = {30'h0, nv_r};
      iopr_pkg::ADR_SIOCFG: rdat = {27'h0, sio_r};
      iopr_pkg::ADR_CTRL:   rdat = {30'h0, ctrl_r};
      default:              rdat = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wr | rd;
      wb_dat_o <= rd ? rdat : 32'h0;
    end
  end

  // Assertions
  load_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    load_r |=> rcfg_r == $past(nv_r)) else $error("load lost");
  stat_set_a: assert property (@(posedge clk) disable iff (!rstn)
    evt[0] |=> stat_r[0]) else $error("event lost");
  irq_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    (|(stat_r & mask_r)) |=> irq) else $error("irq missing");
  wake_pin_a: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_r[0] && |(evt & mask_r)) |=> wake_o) else $error("no wake");
  ack_one_a: assert property (@(posedge clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
  dm_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (!load_r && !wr) |=> $stable(dm_r)) else $error("dm moved");
  pad_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (lp_mode_o && !wr) [*2] |=> $stable(pad_o)) else $error("pad moved");
  sio_thr_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> sio_o.thr_sel == $past(sio_r[2:0])) else $error("thr");
  cov_wake_c: cover property (@(posedge clk) wake_o);
  cov_irq_c: cover property (@(posedge clk) irq);
  cov_load_c: cover property (@(posedge clk) load_r && nv_r == 2'h2);
endmodule // iopr_port
`default_nettype wire
